// ===== dv/timer_ccr_control_irq_vector_tb_top.sv
// bench for the capture/compare timer: bus tasks and directed register sequences
// assumes the design checks itself with its own assertions; bench drives all pins
module timer_ccr_control_irq_vector_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import tccr_pkg::*;
    logic        clk = 1'b0, reset = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h3;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp, last_resp;
    logic [2:0]  chan_a = 3'h0, chan_b = 3'h0, channel_out;
    int          n_mismatch = 0, compares = 0;

    always #2.5 clk = ~clk;

    tccr_timer tccr_timer_i (.clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .channel_input_a(chan_a), .channel_input_b(chan_b), .channel_out(channel_out),
        .irq(irq));

    task automatic stop_test();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic bound(input int n);
        if (n > 200) begin
            n_mismatch++;
            stop_test();
        end
    endtask : bound

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        int   n;
        logic ta, tw, tb;
        n = 0;
        ta = 1'b0;
        tw = 1'b0;
        tb = 1'b0;
        awaddr <= a;
        wdata <= {16'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb) begin
            @(negedge clk);
            ta = ta | (awvalid & awready);
            tw = tw | (wvalid & wready);
            tb = bvalid;
            last_resp = bresp;
            @(posedge clk);
            if (ta && awvalid) awvalid <= 1'b0;
            if (tw && wvalid) wvalid <= 1'b0;
            n++;
            bound(n);
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        int   n;
        logic tr, tk;
        logic [31:0] d;
        n = 0;
        tr = 1'b0;
        tk = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr) begin
            @(negedge clk);
            tk = tk | (arvalid & arready);
            tr = rvalid;
            d = rdata;
            last_resp = rresp;
            @(posedge clk);
            if (tk && arvalid) arvalid <= 1'b0;
            n++;
            bound(n);
        end
        chk(d, exp);
    endtask : rd

    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(8'h20, 32'h0);
        rd(8'h2c, 32'h0);
        chk({30'h0, last_resp}, {30'h0, RESP_SLVERR});
        wr(8'h2c, 16'h0001);
        chk({30'h0, last_resp}, {30'h0, RESP_SLVERR});
        wr(8'h0c, 16'h0204);
        chk({30'h0, last_resp}, {30'h0, RESP_OKAY});
        rd(8'h0c, 32'h0004);
        chk({30'h0, last_resp}, {30'h0, RESP_OKAY});
        chk({29'h0, channel_out}, 32'h2);
        wr(8'h0c, 16'h0000);
        @(posedge clk);
        chk({29'h0, channel_out}, 32'h0);
        chan_a <= 3'h2;
        repeat (4) @(posedge clk);
        rd(8'h0c, 32'h0008);
        wr(8'h08, 16'h0000);
        wr(8'h14, 16'h0010);
        wr(8'h18, 16'h0004);
        wr(8'h0c, 16'h0020);
        wr(8'h00, 16'h0014);
        repeat (40) @(posedge clk);
        chk({31'h0, channel_out[1]}, 32'h1);
        wr(8'h0c, 16'h00a0);
        repeat (40) @(posedge clk);
        chk({31'h0, channel_out[1]}, 32'h0);
        wr(8'h00, 16'h0000);
        rd(8'h0c, 32'h04a9);
        rd(8'h08, 32'h0001);
        rd(8'h20, 32'h0);
        wr(8'h24, 16'h000f);
        wr(8'h28, 16'h0006);
        wr(8'h1c, 16'h0006);
        wr(8'h0c, 16'h0010);
        wr(8'h10, 16'h0090);
        wr(8'h00, 16'h0014);
        repeat (40) @(posedge clk);
        wr(8'h00, 16'h0000);
        chk({31'h0, irq}, 32'h1);
        rd(8'h20, {16'h0, VEC_CH1});
        rd(8'h20, {16'h0, VEC_CH2});
        rd(8'h20, {16'h0, VEC_NONE});
        wr(8'h24, 16'h0006);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        // stopped counter preset, then a synchronised rising capture on channel 1
        wr(8'h04, 16'h1234);
        wr(8'h0c, 16'h4900);
        chan_a <= 3'h0;
        repeat (4) @(posedge clk);
        chan_a <= 3'h2;
        repeat (6) @(posedge clk);
        rd(8'h18, 32'h1234);
        rd(8'h0c, 32'h4d09); // and
        stop_test();
    end
endmodule : timer_ccr_control_irq_vector_tb_top

// ===== rtl/tccr_pkg.sv
// constants shared by the capture/compare timer block
// assumes one 200 MHz clock and an AXI4-Lite register bus with 8-bit addresses
package tccr_pkg;
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 32;
    localparam int          NCH         = 3;
    localparam int          NIRQ        = 4;

    // register indexes; byte address is index times four
    localparam logic [3:0]  IDX_TCTL    = 4'h0;
    localparam logic [3:0]  IDX_CNT     = 4'h1;
    localparam logic [3:0]  IDX_CCTL0   = 4'h2;
    localparam logic [3:0]  IDX_CCR0    = 4'h5;
    localparam logic [3:0]  IDX_VEC     = 4'h8;
    localparam logic [3:0]  IDX_ISTAT   = 4'h9;
    localparam logic [3:0]  IDX_IMASK   = 4'ha;
    localparam logic [3:0]  IDX_LAST    = 4'ha;

    // timer control fields
    localparam int          CT_FLAG     = 0;
    localparam int          CT_OIE      = 1;
    localparam int          CT_CLR      = 2;
    localparam int          CT_MODE_LO  = 4;

    // channel control fields
    localparam int          CC_FLAG     = 0;
    localparam int          CC_COV      = 1;
    localparam int          CC_OUT      = 2;
    localparam int          CC_LIVE     = 3;
    localparam int          CC_IE       = 4;
    localparam int          CC_WM_LO    = 5;
    localparam int          CC_CAP      = 8;
    localparam int          CC_LATCH    = 10;
    localparam int          CC_SYNC     = 11;
    localparam int          CC_SEL_LO   = 12;
    localparam int          CC_EDGE_LO  = 14;

    typedef enum logic [1:0] {CNT_STOP, CNT_UP, CNT_CONT, CNT_UPDOWN} tccr_count_t;

    localparam logic [2:0]  WM_OUT      = 3'h0;
    localparam logic [2:0]  WM_SET      = 3'h1;
    localparam logic [2:0]  WM_TOG_RST  = 3'h2;
    localparam logic [2:0]  WM_SET_RST  = 3'h3;
    localparam logic [2:0]  WM_TOG      = 3'h4;
    localparam logic [2:0]  WM_RST      = 3'h5;
    localparam logic [2:0]  WM_TOG_SET  = 3'h6;
    localparam logic [2:0]  WM_RST_SET  = 3'h7;

    localparam logic [15:0] VEC_NONE    = 16'h0000;
    localparam logic [15:0] VEC_CH1     = 16'h0002;
    localparam logic [15:0] VEC_CH2     = 16'h0004;
    localparam logic [15:0] VEC_OVF     = 16'h000a;

    localparam logic [15:0] CNT_RESET   = 16'h0000;
    localparam logic [15:0] CNT_MAX     = 16'hffff;
    localparam logic [3:0]  IMASK_RESET = 4'h0;
    localparam int          IRQ_OVF     = 3;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : tccr_pkg

// ===== rtl/tccr_timer.sv
// 16-bit timer with three capture/compare channels, vector register and irq
// assumes an AXI4-Lite master on clk; channel inputs are asynchronous pins
// Function
// - sync bit set: capture from a further clocked stage; clear: capture directly
// - selected input latched on channel equal event, readable in bit 10
// - channel control bit 9 ignores writes and reads zero
// - bits 7-5 pick output mode: out, set, tog/rst, set/rst, tog, rst, tog/set, rst/set
// - channel irq enable bit gates the channel request
// - bit 3 reads the present level of the selected input
// - mode 0 drives the output from the output bit
// - vector reports highest pending: 02h ch1, 04h ch2, 0ah overflow, 00h none
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
module tccr_timer
    import tccr_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic [tccr_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                      awvalid,
    output      logic                      awready,
    input  wire logic [tccr_pkg::DATA_W-1:0] wdata,
    input  wire logic [3:0]                wstrb,
    input  wire logic                      wvalid,
    output      logic                      wready,
    output      logic [1:0]                bresp,
    output      logic                      bvalid,
    input  wire logic                      bready,
    input  wire logic [tccr_pkg::ADDR_W-1:0] araddr,
    input  wire logic                      arvalid,
    output      logic                      arready,
    output      logic [tccr_pkg::DATA_W-1:0] rdata,
    output      logic [1:0]                rresp,
    output      logic                      rvalid,
    input  wire logic                      rready,
    input  wire logic [tccr_pkg::NCH-1:0]  channel_input_a,
    input  wire logic [tccr_pkg::NCH-1:0]  channel_input_b,
    output      logic [tccr_pkg::NCH-1:0]  channel_out,
    output      logic                      irq
);
    import tccr_pkg::*;

    function automatic logic idx_mapped(input logic [ADDR_W-1:0] a);
        return (a[1:0] == 2'h0) && (a[7:6] == 2'h0) && (a[5:2] <= IDX_LAST);
    endfunction : idx_mapped

    function automatic logic wave_next(input logic [2:0] m, input logic cur,
                                       input logic obit, input logic eqx, input logic eq0);
        logic r;
        r = cur;
        case (m)
            WM_OUT:     r = obit;
            WM_SET:     r = eqx ? 1'b1 : cur;
            WM_TOG_RST: r = eqx ? ~cur : (eq0 ? 1'b0 : cur);
            WM_SET_RST: r = eqx ? 1'b1 : (eq0 ? 1'b0 : cur);
            WM_TOG:     r = eqx ? ~cur : cur;
            WM_RST:     r = eqx ? 1'b0 : cur;
            WM_TOG_SET: r = eqx ? ~cur : (eq0 ? 1'b1 : cur);
            WM_RST_SET: r = eqx ? 1'b0 : (eq0 ? 1'b1 : cur);
            default:    r = cur;
        endcase
        return r;
    endfunction : wave_next

    // bus state
    logic                aw_full_reg;
    logic [ADDR_W-1:0]   aw_addr_reg;
    logic                w_full_reg;
    logic [15:0]         w_data_reg;
    logic [1:0]          w_strb_reg;
    logic                wr_do;
    logic                rd_take;
    logic [ADDR_W-1:0]   rd_addr_reg;
    logic [15:0]         wr_sel;
    logic [15:0]         wword;
    logic [15:0]         reg_view [0:15];
    logic [15:0]         old_word;

    // timer state
    tccr_count_t         mode_reg;
    logic                ovf_ie_reg;
    logic                ovf_flag_reg;
    logic [15:0]         counter_reg;
    logic [15:0]         counter_next;
    logic                dir_down_reg;
    logic                dir_down_next;
    logic                ovf_set;
    logic                counting;

    // channel state
    logic [NCH-1:0]      a_s1_reg, a_s2_reg, b_s1_reg, b_s2_reg;
    logic [NCH-1:0]      sel_in, sel_d1_reg, sel_d2_reg;
    logic [NCH-1:0]      cap_evt, equ, set_flag, vec_clr_ch;
    logic [1:0]          edge_reg  [NCH];
    logic [1:0]          sel_reg   [NCH];
    logic [2:0]          wmode_reg [NCH];
    logic [15:0]         ccr_reg   [NCH];
    logic [NCH-1:0]      sync_reg, cap_mode_reg, ie_reg, out_bit_reg;
    logic [NCH-1:0]      cov_reg, flag_reg, latched_reg, out_reg;
    logic                vec_clr_ovf;
    logic [15:0]         vec_word;
    logic [NIRQ-1:0]     irq_evt, irq_status_reg, irq_mask_reg;

    // write channel: address and data taken in either order
    assign awready = ~aw_full_reg;
    assign wready  = ~w_full_reg;
    assign wr_do   = aw_full_reg & w_full_reg & ~bvalid;

    always_ff @(posedge clk) begin
        if (reset) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (awvalid && awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= awaddr;
        end else if (wr_do) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            w_full_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else if (wvalid && wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= wdata[15:0];
            w_strb_reg <= wstrb[1:0];
        end else if (wr_do) begin
            w_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wr_do) begin
            bvalid <= 1'b1;
            bresp  <= idx_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    assign wr_sel   = (wr_do && idx_mapped(aw_addr_reg)) ? (16'h0001 << aw_addr_reg[5:2]) : '0;
    assign old_word = reg_view[aw_addr_reg[5:2]];
    assign wword    = {w_strb_reg[1] ? w_data_reg[15:8] : old_word[15:8],
                       w_strb_reg[0] ? w_data_reg[7:0]  : old_word[7:0]};

    // read channel
    assign arready = ~rvalid;
    assign rd_take = arvalid & arready;

    always_ff @(posedge clk) begin
        if (reset) begin
            rvalid      <= 1'b0;
            rdata       <= '0;
            rresp       <= RESP_OKAY;
            rd_addr_reg <= '0;
        end else if (rd_take) begin
            rvalid      <= 1'b1;
            rd_addr_reg <= araddr;
            rdata       <= idx_mapped(araddr) ? {16'h0000, reg_view[araddr[5:2]]} : '0;
            rresp       <= idx_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    always_comb begin
        for (int k = 0; k < 16; k++) begin
            reg_view[k] = '0;
        end
        reg_view[IDX_TCTL]  = {10'h000, mode_reg, 2'h0, ovf_ie_reg, ovf_flag_reg};
        reg_view[IDX_CNT]   = counter_reg;
        reg_view[IDX_VEC]   = vec_word;
        reg_view[IDX_ISTAT] = {12'h000, irq_status_reg};
        reg_view[IDX_IMASK] = {12'h000, irq_mask_reg};
        for (int c = 0; c < NCH; c++) begin
            // bit 9 stays zero, bit 3 shows the live input; and
            reg_view[IDX_CCTL0 + c] = {edge_reg[c], sel_reg[c], sync_reg[c], latched_reg[c],
                                       1'b0, cap_mode_reg[c], wmode_reg[c], ie_reg[c],
                                       sel_in[c], out_bit_reg[c], cov_reg[c], flag_reg[c]};
            reg_view[IDX_CCR0 + c]  = ccr_reg[c];
        end
    end

    // counter
    assign counting = (mode_reg != CNT_STOP);

    always_comb begin
        counter_next  = counter_reg;
        dir_down_next = dir_down_reg;
        ovf_set       = 1'b0;
        case (mode_reg)
            CNT_UP: begin
                if (counter_reg >= ccr_reg[0]) begin
                    counter_next = CNT_RESET;
                    ovf_set      = 1'b1;
                end else begin
                    counter_next = counter_reg + 16'h0001;
                end
            end
            CNT_CONT: begin
                counter_next = counter_reg + 16'h0001;
                ovf_set      = (counter_reg == CNT_MAX);
            end
            CNT_UPDOWN: begin
                if (dir_down_reg) begin
                    if (counter_reg <= 16'h0001) begin
                        counter_next  = CNT_RESET;
                        dir_down_next = 1'b0;
                        ovf_set       = (counter_reg == 16'h0001);
                    end else begin
                        counter_next = counter_reg - 16'h0001;
                    end
                end else if (counter_reg >= ccr_reg[0] && counter_reg != CNT_RESET) begin
                    counter_next  = counter_reg - 16'h0001;
                    dir_down_next = 1'b1;
                end else if (ccr_reg[0] != CNT_RESET) begin
                    counter_next = counter_reg + 16'h0001;
                end
            end
            default: begin
                counter_next = counter_reg;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            counter_reg  <= CNT_RESET;
            dir_down_reg <= 1'b0;
        end else if (wr_sel[IDX_TCTL] && wword[CT_CLR]) begin
            counter_reg  <= CNT_RESET;
            dir_down_reg <= 1'b0;
        end else if (wr_sel[IDX_CNT]) begin
            counter_reg <= wword;
        end else begin
            counter_reg  <= counter_next;
            dir_down_reg <= dir_down_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_reg   <= CNT_STOP;
            ovf_ie_reg <= 1'b0;
        end else if (wr_sel[IDX_TCTL]) begin
            mode_reg   <= tccr_count_t'(wword[CT_MODE_LO +: 2]);
            ovf_ie_reg <= wword[CT_OIE];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ovf_flag_reg <= 1'b0;
        end else if (ovf_set) begin
            ovf_flag_reg <= 1'b1;
        end else if (wr_sel[IDX_TCTL]) begin
            ovf_flag_reg <= wword[CT_FLAG];
        end else if (vec_clr_ovf) begin
            ovf_flag_reg <= 1'b0;
        end
    end

    // pin synchronisers
    always_ff @(posedge clk) begin
        if (reset) begin
            a_s1_reg   <= '0;
            a_s2_reg   <= '0;
            b_s1_reg   <= '0;
            b_s2_reg   <= '0;
            sel_d1_reg <= '0;
            sel_d2_reg <= '0;
        end else begin
            a_s1_reg   <= channel_input_a;
            a_s2_reg   <= a_s1_reg;
            b_s1_reg   <= channel_input_b;
            b_s2_reg   <= b_s1_reg;
            sel_d1_reg <= sel_in;
            sel_d2_reg <= sel_d1_reg;
        end
    end

    // channels
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic cap_now;
        logic cap_prev;

        always_comb begin
            case (sel_reg[i])
                2'h0:    sel_in[i] = a_s2_reg[i];
                2'h1:    sel_in[i] = b_s2_reg[i];
                2'h2:    sel_in[i] = 1'b0;
                default: sel_in[i] = 1'b1;
            endcase
        end

        assign cap_now     = sync_reg[i] ? sel_d1_reg[i] : sel_in[i];
        assign cap_prev    = sync_reg[i] ? sel_d2_reg[i] : sel_d1_reg[i];
        assign cap_evt[i]  = cap_mode_reg[i] & ((edge_reg[i][0] & cap_now & ~cap_prev) |
                                                (edge_reg[i][1] & ~cap_now & cap_prev));
        assign equ[i]      = counting & (counter_reg == ccr_reg[i]);
        assign set_flag[i] = cap_evt[i] | (~cap_mode_reg[i] & equ[i]);

        always_ff @(posedge clk) begin
            if (reset) begin
                edge_reg[i]     <= '0;
                sel_reg[i]      <= '0;
                sync_reg[i]     <= 1'b0;
                cap_mode_reg[i] <= 1'b0;
                wmode_reg[i]    <= WM_OUT;
                ie_reg[i]       <= 1'b0;
                out_bit_reg[i]  <= 1'b0;
            end else if (wr_sel[IDX_CCTL0 + i]) begin
                edge_reg[i]     <= wword[CC_EDGE_LO +: 2];
                sel_reg[i]      <= wword[CC_SEL_LO +: 2];
                sync_reg[i]     <= wword[CC_SYNC];
                cap_mode_reg[i] <= wword[CC_CAP];
                wmode_reg[i]    <= wword[CC_WM_LO +: 3];
                ie_reg[i]       <= wword[CC_IE];
                out_bit_reg[i]  <= wword[CC_OUT];
            end
        end

        always_ff @(posedge clk) begin
            if (reset) begin
                flag_reg[i] <= 1'b0;
            end else if (set_flag[i]) begin
                flag_reg[i] <= 1'b1;
            end else if (wr_sel[IDX_CCTL0 + i]) begin
                flag_reg[i] <= wword[CC_FLAG];
            end else if (vec_clr_ch[i]) begin
                flag_reg[i] <= 1'b0;
            end
        end

        always_ff @(posedge clk) begin
            if (reset) begin
                cov_reg[i] <= 1'b0;
            end else if (cap_evt[i] && flag_reg[i]) begin
                cov_reg[i] <= 1'b1;
            end else if (wr_sel[IDX_CCTL0 + i]) begin
                cov_reg[i] <= wword[CC_COV];
            end
        end

        always_ff @(posedge clk) begin
            if (reset) begin
                ccr_reg[i] <= CNT_RESET;
            end else if (cap_evt[i]) begin
                ccr_reg[i] <= counter_reg;
            end else if (wr_sel[IDX_CCR0 + i]) begin
                ccr_reg[i] <= wword;
            end
        end

        always_ff @(posedge clk) begin
            if (reset) begin
                latched_reg[i] <= 1'b0;
            end else if (equ[i]) begin
                latched_reg[i] <= sel_in[i];
            end
        end

        always_ff @(posedge clk) begin
            if (reset) begin
                out_reg[i] <= 1'b0;
            end else begin
                // and
                out_reg[i] <= wave_next(wmode_reg[i], out_reg[i], out_bit_reg[i], equ[i], equ[0]);
            end
        end

        assign irq_evt[i] = set_flag[i] & ie_reg[i];
    end

    assign channel_out = out_reg;

    // vector: priority ch1, ch2, overflow
    always_comb begin
        if (flag_reg[1] && ie_reg[1]) begin // and
            vec_word = VEC_CH1;
        end else if (flag_reg[2] && ie_reg[2]) begin
            vec_word = VEC_CH2;
        end else if (ovf_flag_reg && ovf_ie_reg) begin
            vec_word = VEC_OVF;
        end else begin
            vec_word = VEC_NONE;
        end
    end

    // reading the vector acknowledges the source it names
    assign vec_clr_ch[0] = 1'b0;
    assign vec_clr_ch[1] = rd_take && idx_mapped(araddr) && araddr[5:2] == IDX_VEC
                           && vec_word == VEC_CH1;
    assign vec_clr_ch[2] = rd_take && idx_mapped(araddr) && araddr[5:2] == IDX_VEC
                           && vec_word == VEC_CH2;
    assign vec_clr_ovf   = rd_take && idx_mapped(araddr) && araddr[5:2] == IDX_VEC
                           && vec_word == VEC_OVF;

    // sticky irq status, write one to clear, set wins
    assign irq_evt[IRQ_OVF] = ovf_set & ovf_ie_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_status_reg <= '0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~(wr_sel[IDX_ISTAT] ? wword[NIRQ-1:0] : '0))
                              | irq_evt;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_mask_reg <= IMASK_RESET;
        end else if (wr_sel[IDX_IMASK]) begin
            irq_mask_reg <= wword[NIRQ-1:0];
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    sync_path_a: assert property (
        cap_evt[1] && sync_reg[1] && $stable(sync_reg[1]) && $stable(sel_reg[1])
        |-> $past(sel_in[1]) != $past(sel_in[1], 2))
        else $error("synchronised capture without delayed input change");
    latch_equal_a: assert property (
        equ[1] |=> latched_reg[1] == $past(sel_in[1]))
        else $error("latched input not taken at equal event");
    unused_zero_a: assert property (
        rvalid && rd_addr_reg[5:2] >= IDX_CCTL0 && rd_addr_reg[5:2] < IDX_CCR0
        |-> rdata[9] == 1'b0)
        else $error("control bit 9 read nonzero");
    mode_set_a: assert property (
        equ[1] && wmode_reg[1] == WM_SET |=> out_reg[1])
        else $error("set mode did not raise output");
    mode_toggle_a: assert property (
        equ[2] && wmode_reg[2] == WM_TOG |=> out_reg[2] != $past(out_reg[2]))
        else $error("toggle mode did not toggle");
    irq_gate_a: assert property (
        !ie_reg[1] && !ie_reg[2] && !ovf_ie_reg |-> vec_word == VEC_NONE ##1 1'b1)
        else $error("disabled source reported");
    live_level_a: assert property (
        rd_take && araddr[5:2] == IDX_CCTL0 && idx_mapped(araddr)
        |=> rdata[CC_LIVE] == $past(sel_in[0]))
        else $error("live input bit wrong");
    direct_out_a: assert property (
        wmode_reg[2] == WM_OUT && $past(wmode_reg[2] == WM_OUT)
        |-> out_reg[2] == $past(out_bit_reg[2]))
        else $error("mode 0 output does not follow output bit");
    vector_prio_a: assert property (
        flag_reg[2] && ie_reg[2] && ovf_flag_reg && ovf_ie_reg && !(flag_reg[1] && ie_reg[1])
        |-> vec_word == VEC_CH2)
        else $error("vector priority wrong");
    vector_bits_a: assert property (
        vec_word[15:4] == 12'h000 && vec_word[0] == 1'b0)
        else $error("vector has bits outside code field");
    capture_copy_a: assert property (
        cap_evt[1] |=> ccr_reg[1] == $past(counter_reg) && flag_reg[1])
        else $error("capture did not copy counter");

    cap_seen_c:  cover property (cap_evt[1] ##[1:20] cap_evt[1]);
    ovf_irq_c:   cover property (ovf_set && ovf_ie_reg ##1 irq);
    vec_read_c:  cover property (vec_clr_ch[1] ##[1:10] vec_clr_ch[2]);
endmodule : tccr_timer
